// ===== hw/dmabm_pkg.sv
// Package with shared constants and types for the DMA bus-mode and request logic
package dmabm_pkg;
	localparam int DMABM_NUM_CH = 4;
	localparam int DMABM_EXT_CH = 2;
	localparam int DMABM_CLK_PERIOD_NS = 50;
	localparam int DMABM_DETECT_STATES = 3;
	localparam logic [1:0] DMABM_WAIT_LAST = 2'(DMABM_DETECT_STATES - 2);
	localparam logic [1:0] DMABM_PEND_MAX = 2'h2;
	localparam logic [3:0] DMABM_ONE_HOT0 = 4'h1;

	typedef enum logic {DMABM_CYCLE_STEAL, DMABM_BURST} dmabm_bus_mode_type;
	typedef enum logic [2:0] {DMABM_SRC_AUTO, DMABM_SRC_EXT, DMABM_SRC_SERIAL,
		DMABM_SRC_ANALOG0, DMABM_SRC_ANALOG1, DMABM_SRC_PERIPH} dmabm_src_type;
	typedef enum logic [1:0] {DMABM_SZ8, DMABM_SZ16, DMABM_SZ32, DMABM_SZ_BAD} dmabm_size_type;

	// One channel's setting, as held in the channel control registers
	typedef struct packed {
		logic enable;
		dmabm_bus_mode_type bus_mode_select;
		dmabm_src_type req_src;
		logic single_addr;
		logic level_detect;
		dmabm_size_type size;
		logic periph_involved;
	} dmabm_chcfg_type;
endpackage

// ===== hw/dmabm_arb.sv
// Channel arbiter with fixed or round-robin priority
`timescale 1ns/1ps
module dmabm_arb
	import dmabm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_rr_mode,
	input wire logic [3:0] i_req,
	input wire logic i_issue,
	output logic [1:0] o_grant_ch,
	output logic o_any
);
	logic [1:0] last_q, last_d;
	logic [1:0] cand;

	// Pick the first requesting channel; round robin starts after the last served one
	always_comb begin
		o_grant_ch = 2'h0;
		o_any = 1'b0;
		cand = 2'h0;
		for (int k = DMABM_NUM_CH; k > 0; k--) begin
			cand = i_rr_mode ? 2'(last_q + 2'(k)) : 2'(k - 1);
			if (i_req[cand]) begin
				o_grant_ch = cand;
				o_any = 1'b1;
			end
		end
		last_d = i_issue ? o_grant_ch : last_q;
	end

	// Last served channel drops to lowest priority
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			last_q <= 2'h3;
		end else if (i_ce) begin
			last_q <= last_d;
		end
	end
endmodule

// ===== hw/dmabm_sampler.sv
// External request sampler with detection delay and accept pulse
`timescale 1ns/1ps
module dmabm_sampler
	import dmabm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_enable,
	input wire logic i_level,
	input wire logic i_burst_edge,
	input wire logic i_dma_request_n,
	input wire logic i_rearm,
	input wire logic i_served,
	input wire logic i_chan_end,
	output logic o_pending,
	output logic o_accept
);
	typedef enum logic [1:0] {SMP_SAMPLE, SMP_WAIT, SMP_HOLD} dmabm_smp_type;
	dmabm_smp_type state_q, state_d;
	logic [1:0] cnt_q, cnt_d, pend_q, pend_d;
	logic prev_n_q, accept_q, accept_d, detect;

	// Detection, delay count and pending units
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		pend_d = pend_q;
		accept_d = 1'b0;
		detect = i_level ? !i_dma_request_n : (prev_n_q && !i_dma_request_n);
		if (i_served && !i_burst_edge && pend_q != 2'h0) begin
			pend_d = 2'(pend_q - 2'h1);
		end
		case (state_q)
			SMP_SAMPLE: begin
				if (i_enable && detect) begin
					state_d = SMP_WAIT;
					cnt_d = 2'h0;
					accept_d = 1'b1;
				end
			end
			SMP_WAIT: begin
				cnt_d = 2'(cnt_q + 2'h1);
				if (cnt_q == DMABM_WAIT_LAST) begin
					state_d = SMP_HOLD;
					if (pend_d != DMABM_PEND_MAX) begin
						pend_d = 2'(pend_d + 2'h1);
					end
				end
			end
			SMP_HOLD: begin
				if (i_burst_edge) begin
					if (i_chan_end) begin
						state_d = SMP_SAMPLE;
					end
				end else if (i_rearm) begin
					state_d = SMP_SAMPLE;
				end
			end
			default: state_d = SMP_SAMPLE;
		endcase
		if (!i_enable || i_chan_end) begin
			pend_d = 2'h0;
			state_d = SMP_SAMPLE;
		end
	end

	// Sampler registers
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= SMP_SAMPLE;
			cnt_q <= 2'h0;
			pend_q <= 2'h0;
			prev_n_q <= 1'b1;
			accept_q <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			prev_n_q <= i_dma_request_n;
			accept_q <= accept_d;
		end
	end

	assign o_pending = pend_q != 2'h0;
	assign o_accept = accept_q;

	a_accept_delay: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce || i_chan_end || !i_enable)
		$rose(accept_q) && pend_q == 2'h0 && !i_served |-> !o_pending ##2 o_pending)
		else $error("request not pending three states after detection");
	a_edge_once: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		state_q == SMP_HOLD && i_burst_edge && !i_chan_end && i_enable |=> !accept_d)
		else $error("second accept during an edge-started burst");
endmodule

// ===== hw/dmabm_ctrl.sv
// Bus-mode control, arbitration and external request handling for four DMA channels
`timescale 1ns/1ps
module dmabm_ctrl
	import dmabm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire dmabm_chcfg_type [DMABM_NUM_CH-1:0] i_cfg,
	input wire logic i_rr_mode,
	input wire logic [DMABM_NUM_CH-1:0] i_end_cond,
	input wire logic [DMABM_NUM_CH-1:0] i_int_req,
	input wire logic [DMABM_NUM_CH-1:0] i_periph_size_ok,
	input wire logic [DMABM_EXT_CH-1:0] i_dma_request_n,
	input wire logic i_bus_grant,
	input wire logic i_cyc_start,
	input wire logic i_cyc_done,
	output logic o_bus_req,
	output logic o_dma_cycle,
	output logic [1:0] o_dma_ch,
	output logic o_dummy,
	output logic [DMABM_NUM_CH-1:0] o_count_dec,
	output logic [DMABM_EXT_CH-1:0] o_request_accepted,
	output logic [DMABM_EXT_CH-1:0] o_transfer_ack,
	output logic [DMABM_NUM_CH-1:0] o_cfg_err
);
	typedef enum logic [1:0] {TOP_IDLE, TOP_ARB, TOP_OWN, TOP_XFER} dmabm_top_type;
	dmabm_top_type state_q, state_d;
	logic bus_req_q, bus_req_d, dma_q, dma_d, dummy_q, dummy_d;
	logic [1:0] ch_q, ch_d;
	logic [3:0] dec_q, dec_d, err_q, err_d, started_q, started_d;
	logic [1:0] transfer_acknowledge_output_q, transfer_acknowledge_output_d, request_accepted_output_q;
	logic [3:0] valid, cfg_bad;
	logic [1:0] ext_pend, ext_acc, rearm;
	logic [1:0] grant_ch;
	logic any_req, issue, burst_live;

	// Per-channel legality and request source; sampler on the external channels 0 and 1 only
	for (genvar c = 0; c < DMABM_NUM_CH; c++) begin : g_ch
		logic src_ext, src_ok;
		assign src_ext = i_cfg[c].req_src == DMABM_SRC_EXT;
		assign cfg_bad[c] = (src_ext && c >= DMABM_EXT_CH)
			|| (i_cfg[c].single_addr && (!src_ext || c >= DMABM_EXT_CH))
			|| (i_cfg[c].req_src == DMABM_SRC_SERIAL && i_cfg[c].bus_mode_select == DMABM_BURST)
			|| i_cfg[c].size == DMABM_SZ_BAD
			|| (i_cfg[c].periph_involved && !i_periph_size_ok[c]);
		if (c < DMABM_EXT_CH) begin : g_ext
			dmabm_sampler u_smp (
				.i_sys_clk(i_sys_clk),
				.i_nrst(i_nrst),
				.i_ce(i_ce),
				.i_enable(i_cfg[c].enable && src_ext && !cfg_bad[c]),
				.i_level(i_cfg[c].level_detect),
				.i_burst_edge(i_cfg[c].bus_mode_select == DMABM_BURST && !i_cfg[c].level_detect),
				.i_dma_request_n(i_dma_request_n[c]),
				.i_rearm(rearm[c]),
				.i_served(issue && grant_ch == 2'(c)),
				.i_chan_end(i_end_cond[c]),
				.o_pending(ext_pend[c]),
				.o_accept(ext_acc[c])
			);
			// Next sampling opens at the start of the bus cycle preceding the transfer
			assign rearm[c] = i_cyc_start && ext_pend[c];
			assign src_ok = src_ext ? ext_pend[c] : i_int_req[c];
		end else begin : g_int
			assign src_ok = i_int_req[c];
		end
		assign valid[c] = i_cfg[c].enable && !cfg_bad[c] && !i_end_cond[c] && src_ok;
	end

	dmabm_arb u_arb (
		.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_rr_mode(i_rr_mode),
		.i_req(valid),
		.i_issue(issue),
		.o_grant_ch(grant_ch),
		.o_any(any_req)
	);

	// Ownership sequence: request bus, issue one unit per bus cycle, keep or release
	always_comb begin
		state_d = state_q;
		bus_req_d = bus_req_q;
		dma_d = dma_q;
		ch_d = ch_q;
		dummy_d = dummy_q;
		transfer_acknowledge_output_d = transfer_acknowledge_output_q;
		dec_d = 4'h0;
		started_d = started_q & valid;
		issue = 1'b0;
		burst_live = 1'b0;
		for (int k = 0; k < DMABM_NUM_CH; k++) begin
			if (valid[k] && i_cfg[k].bus_mode_select == DMABM_BURST) begin
				burst_live = 1'b1;
			end
		end
		case (state_q)
			TOP_IDLE: begin
				if (any_req) begin
					state_d = TOP_ARB;
					bus_req_d = 1'b1;
				end
			end
			TOP_ARB: begin
				if (!any_req) begin
					state_d = TOP_IDLE;
					bus_req_d = 1'b0;
				end else if (i_bus_grant) begin
					state_d = TOP_OWN;
				end
			end
			TOP_OWN: begin
				if (i_cyc_start) begin
					if (any_req) begin
						issue = 1'b1;
						state_d = TOP_XFER;
						dma_d = 1'b1;
						ch_d = grant_ch;
						dummy_d = i_cfg[grant_ch].single_addr && !started_q[grant_ch]
							&& i_cfg[grant_ch].bus_mode_select == DMABM_BURST;
						if (i_cfg[grant_ch].single_addr && !dummy_d && grant_ch < 2'(DMABM_EXT_CH)) begin
							transfer_acknowledge_output_d = 2'(DMABM_ONE_HOT0 << grant_ch);
						end
					end else begin
						state_d = TOP_IDLE;
						bus_req_d = 1'b0;
					end
				end
			end
			TOP_XFER: begin
				if (i_cyc_done) begin
					dma_d = 1'b0;
					transfer_acknowledge_output_d = 2'h0;
					dummy_d = 1'b0;
					started_d[ch_q] = 1'b1;
					if (!dummy_q) begin
						dec_d = DMABM_ONE_HOT0 << ch_q;
					end
					if (burst_live) begin
						state_d = TOP_OWN;
					end else begin
						state_d = TOP_IDLE;
						bus_req_d = 1'b0;
						started_d = 4'h0;
					end
				end
			end
			default: begin
				state_d = TOP_IDLE;
				bus_req_d = 1'b0;
			end
		endcase
		err_d = cfg_bad;
	end

	// Ownership registers and output flops
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= TOP_IDLE;
			bus_req_q <= 1'b0;
			dma_q <= 1'b0;
			ch_q <= 2'h0;
			dummy_q <= 1'b0;
			transfer_acknowledge_output_q <= 2'h0;
			dec_q <= 4'h0;
			started_q <= 4'h0;
			err_q <= 4'h0;
			request_accepted_output_q <= 2'h0;
		end else if (i_ce) begin
			state_q <= state_d;
			bus_req_q <= bus_req_d;
			dma_q <= dma_d;
			ch_q <= ch_d;
			dummy_q <= dummy_d;
			transfer_acknowledge_output_q <= transfer_acknowledge_output_d;
			dec_q <= dec_d;
			started_q <= started_d;
			err_q <= err_d;
			request_accepted_output_q <= ext_acc;
		end
	end

	assign o_bus_req = bus_req_q;
	assign o_dma_cycle = dma_q;
	assign o_dma_ch = ch_q;
	assign o_dummy = dummy_q;
	assign o_count_dec = dec_q;
	assign o_transfer_ack = transfer_acknowledge_output_q;
	assign o_request_accepted = request_accepted_output_q;
	assign o_cfg_err = err_q;

	a_dummy_uncounted: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		state_q == TOP_XFER && dummy_q && i_cyc_done |=> dec_q == 4'h0 && !dma_q)
		else $error("dummy cycle decremented the count");
	a_unit_counted: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		state_q == TOP_XFER && !dummy_q && i_cyc_done |=> dec_q == (DMABM_ONE_HOT0 << $past(ch_q)))
		else $error("finished unit not counted on its channel");
	a_ack_span: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		transfer_acknowledge_output_q != 2'h0 |-> dma_q && !dummy_q && transfer_acknowledge_output_q == 2'(DMABM_ONE_HOT0 << ch_q))
		else $error("acknowledge outside a real transfer cycle");
	a_ext_channels: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		issue && i_cfg[grant_ch].req_src == DMABM_SRC_EXT |-> grant_ch < 2'(DMABM_EXT_CH))
		else $error("external request served on channel 2 or 3");
	a_serial_steal: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		issue |-> !(i_cfg[grant_ch].req_src == DMABM_SRC_SERIAL && i_cfg[grant_ch].bus_mode_select == DMABM_BURST))
		else $error("serial-requested channel ran in burst mode");
	a_size_legal: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		issue |-> i_cfg[grant_ch].size != DMABM_SZ_BAD)
		else $error("unit issued with illegal size");
	a_burst_holds: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		state_q == TOP_XFER && i_cyc_done && burst_live |=> bus_req_q ##1 bus_req_q)
		else $error("bus released while a burst channel is active");
	a_steal_release: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		state_q == TOP_XFER && i_cyc_done && !burst_live |=> !bus_req_q && state_q == TOP_IDLE)
		else $error("bus kept after a cycle-steal unit");
	a_ch0_first: assert property (@(posedge i_sys_clk) disable iff (!i_nrst || !i_ce)
		issue && valid[0] && !i_rr_mode |-> grant_ch == 2'h0)
		else $error("channel 0 request did not win under fixed priority");
endmodule

// ===== verif/dmabm_far.sv
// Far side model: bus arbiter, bus cycle sequencer and one external requesting device
`timescale 1ns/1ps
module dmabm_far
	import dmabm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_bus_req,
	input wire logic i_accepted,
	input wire logic i_go,
	output logic o_bus_grant,
	output logic o_cyc_start,
	output logic o_cyc_done,
	output logic o_dma_request_n
);
	logic [1:0] ph_q;
	logic sent_q;
	// Bus cycles of four states run whoever owns the bus; grant trails request by one cycle
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ph_q <= 2'h0;
			o_bus_grant <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			o_bus_grant <= i_bus_req;
		end
	end
	assign o_cyc_start = (ph_q == 2'h0);
	assign o_cyc_done = (ph_q == 2'h2);
	// Request goes low once per go and is negated on the accept pulse
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_dma_request_n <= 1'b1;
			sent_q <= 1'b0;
		end else if (!i_go) begin
			o_dma_request_n <= 1'b1;
			sent_q <= 1'b0;
		end else if (!sent_q) begin
			o_dma_request_n <= 1'b0;
			sent_q <= 1'b1;
		end else if (i_accepted) begin
			o_dma_request_n <= 1'b1;
		end
	end
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the DMA bus-mode and request control
`timescale 1ns/1ps
module testbench;
	import dmabm_pkg::*;
	logic clk, nrst, ce, rr, go, pre;
	dmabm_chcfg_type [3:0] cfg;
	logic [3:0] endc, ireq, szok, dec, err;
	logic grant, cs, cd, rq_n, breq, dcyc, dum, cdl, brel;
	logic [1:0] dch, acc, ack;
	int fails, n_tests, cyc, nacc, nack, ndum;
	int ndec[4];
	int tgt[4];
	logic [31:0] exq[$];
	logic [31:0] seed;
	logic [1:0] sq[2][6];
	// Clock of 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	dmabm_ctrl i_dut(.i_sys_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cfg(cfg), .i_rr_mode(rr),
		.i_end_cond(endc), .i_int_req(ireq), .i_periph_size_ok(szok), .i_dma_request_n({1'b1, rq_n}),
		.i_bus_grant(grant), .i_cyc_start(cs), .i_cyc_done(cd), .o_bus_req(breq), .o_dma_cycle(dcyc),
		.o_dma_ch(dch), .o_dummy(dum), .o_count_dec(dec), .o_request_accepted(acc),
		.o_transfer_ack(ack), .o_cfg_err(err));
	dmabm_far i_far(.i_sys_clk(clk), .i_nrst(nrst), .i_bus_req(breq), .i_accepted(acc[0]), .i_go(go),
		.o_bus_grant(grant), .o_cyc_start(cs), .o_cyc_done(cd), .o_dma_request_n(rq_n));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic rst;
		nrst <= 1'b0;
		ireq <= 4'h0;
		endc <= 4'h0;
		go <= 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		ndec = '{0, 0, 0, 0};
		tgt = '{0, 0, 0, 0};
		nacc = 0;
		nack = 0;
		ndum = 0;
	endtask
	// Legal auto-request setting for one channel
	task automatic set_auto(input int c, input dmabm_bus_mode_type m);
		cfg[c] <= '{1'b1, m, DMABM_SRC_AUTO, 1'b0, 1'b1, DMABM_SZ16, 1'b0};
	endtask
	task automatic wait_q;
		for (int i = 0; i < 600 && exq.size() > 0; i++) @(posedge clk);
		repeat (8) @(posedge clk);
		chk(exq.size(), 0);
	endtask
	// Monitor: compare each decrement with the oldest note, react to counts
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up();
		end
		if (acc[0] === 1'b1) nacc++;
		if (ack[0] === 1'b1) nack++;
		// Bus request as left by the edge that ended the unit
		if (cdl === 1'b1) brel = breq;
		cdl <= cd;
		// Count units where they end, so the end condition is in place before the next cycle start
		if (cd === 1'b1 && dcyc === 1'b1 && dum === 1'b1) ndum++;
		if (cd === 1'b1 && dcyc === 1'b1 && dum === 1'b0) begin
			ndec[dch]++;
			if (ndec[dch] == tgt[dch]) endc[dch] <= 1'b1;
			if (pre && dch == 2'h1) ireq[0] <= 1'b1;
		end
		if (dec !== 4'h0) begin
			chk(32'({brel, dec}), exq.size() ? exq.pop_front() : 32'hDEAD);
		end
	end
	initial begin
		fails = 0;
		n_tests = 0;
		cyc = 0;
		pre = 1'b0;
		seed = 32'hB35C;
		ce = 1'b1;
		rr = 1'b0;
		szok = 4'hF;
		sq = '{'{2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1}, '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1}};
		for (int c = 0; c < 4; c++) set_auto(c, DMABM_CYCLE_STEAL);
		rst();
		// Illegal combinations flagged per channel
		cfg[0].single_addr <= 1'b1;
		cfg[1].size <= DMABM_SZ_BAD;
		cfg[2].req_src <= DMABM_SRC_EXT;
		cfg[3] <= '{1'b1, DMABM_BURST, DMABM_SRC_SERIAL, 1'b0, 1'b1, DMABM_SZ8, 1'b1};
		repeat (3) @(posedge clk);
		chk(err, 4'hF);
		for (int c = 0; c < 4; c++) set_auto(c, DMABM_CYCLE_STEAL);
		repeat (3) @(posedge clk);
		chk(err, 4'h0);
		cfg[0].periph_involved <= 1'b1;
		szok[0] <= 1'b0;
		repeat (3) @(posedge clk);
		chk(err, 4'h1);
		szok[0] <= 1'b1;
		$display("Test config checks done");
		// Cycle steal on channel 2 with a random unit count
		rst();
		set_auto(0, DMABM_CYCLE_STEAL);
		seed = xs(seed);
		tgt[2] = 1 + int'(seed % 3);
		for (int i = 0; i < tgt[2]; i++) exq.push_back(32'h04);
		ireq[2] <= 1'b1;
		wait_q();
		$display("Test cycle steal done");
		// Channel 0 preempts a channel 1 burst, fixed then round robin
		for (int r = 0; r < 2; r++) begin
			rst();
			rr <= r[0];
			set_auto(0, DMABM_CYCLE_STEAL);
			set_auto(1, DMABM_BURST);
			tgt[0] = 2;
			tgt[1] = 4;
			pre = 1'b1;
			for (int i = 0; i < 6; i++) exq.push_back(32'h10 | (32'h1 << sq[r][i]));
			ireq[1] <= 1'b1;
			wait_q();
			pre = 1'b0;
			$display("Test preemption mode %0d done", r);
		end
		// External request on channel 0, single address: cycle steal level, then burst edge with dummy
		for (int m = 0; m < 2; m++) begin
			rst();
			rr <= 1'b0;
			cfg[0] <= '{1'b1, dmabm_bus_mode_type'(m), DMABM_SRC_EXT, 1'b1, m == 0, DMABM_SZ8, 1'b0};
			tgt[0] = m + 1;
			for (int i = 0; i <= m; i++) exq.push_back(32'h01 | (32'(m) << 4));
			go <= 1'b1;
			wait_q();
			chk(nacc, 1);
			chk(nack, 2 * (m + 1));
			chk(ndum, m);
			$display("Test external request mode %0d done", m);
		end
		wrap_up();
	end
endmodule
